/* design/pcfg_regs.vh */
`ifndef PCFG_REGS_VH
`define PCFG_REGS_VH
// Configuration byte address in external-data space
`define PCFG_CFG1_ADDR      16'hFD00
// Field positions of configuration byte one
`define PCFG_WATCHDOG_ENABLE_CFG_BIT       7
`define PCFG_RPD_BIT        6
`define PCFG_PORT_RESET_LEVEL_CFG_BIT       5
`define PCFG_BOV_BIT        4
`define PCFG_CLOCK_RATE_CFG_BIT       3
`define PCFG_OSC_HI         2
`define PCFG_OSC_LO         0
// Unprogrammed values
`define PCFG_CFG1_RESET     8'hFF
`define PCFG_SEC_RESET      2'h3
// Oscillator select codes
`define PCFG_OSC_EXT        3'h7
`define PCFG_OSC_RC         3'h3
`define PCFG_OSC_LOW        3'h2
`define PCFG_OSC_MED        3'h1
`define PCFG_OSC_HIGH       3'h0
// Oscillator source one-hot indices
`define PCFG_SRC_EXT        0
`define PCFG_SRC_RC         1
`define PCFG_SRC_LOW        2
`define PCFG_SRC_MED        3
`define PCFG_SRC_HIGH       4
`define PCFG_SRC_W          5
// Programming command codes
`define PCFG_CMD_PROG       2'h0
`define PCFG_CMD_VERIFY     2'h1
`define PCFG_CMD_PROG_SB1   2'h2
`define PCFG_CMD_PROG_SB2   2'h3
`endif

/* design/pcfg_security.v */
`timescale 1ns/1ps
`include "pcfg_regs.vh"
module pcfg_security
(
   // Security bits, 1 = unprogrammed
   input  wire       security_bit_one,
   input  wire       security_bit_two,
   // Decoded permissions
   output wire       prog_allow,
   output wire       verify_allow,
   output wire       sb2_prog_allow,
   output wire       unsupported
);
   assign prog_allow     = security_bit_one & security_bit_two;
   assign verify_allow   = security_bit_two;
   assign sb2_prog_allow = security_bit_two;
   assign unsupported    = security_bit_one & ~security_bit_two;
endmodule

/* design/pcfg_loader.v */
`timescale 1ns/1ps
`include "pcfg_regs.vh"
// Function
// - Configuration latched at power-up; program cannot change it afterwards.
// - Program reads configuration byte at fixed external-data address, no write.
// - Bit 7 at 0 disables watchdog reset; timer interrupt still allowed.
// - Bit 6 at 1 makes reset pin an input-only port bit.
// - Bit 5 sets port reset level high when 1, low when 0.
// - Bit 4 selects 2.5V brownout threshold when 1, 3.8V when 0.
// - Oscillator bits decode external, RC 6 MHz, low, medium, high crystal.
// - Both security bits unprogrammed allow programming and verification.
// - No security bit programmed: verify returns code memory contents.
// - Only bit one programmed: code programming refused, bit two allowed.
// - Both bits programmed: verify and programming refused.
module pcfg_loader
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // Non-volatile array contents
   input  wire [7:0]  nv_cfg1,
   input  wire        nv_sb1,
   input  wire        nv_sb2,
   // Program read port
   input  wire        xrd_req,
   input  wire [15:0] xrd_addr,
   output reg  [7:0]  xrd_data,
   output reg         xrd_hit,
   // Programmer command port
   input  wire        pgm_req,
   input  wire [1:0]  pgm_cmd,
   input  wire [7:0]  pgm_code_rdata,
   output reg         pgm_ack,
   output reg         pgm_refused,
   output reg  [7:0]  pgm_rdata,
   output reg         code_write_en,
   output reg         sb1_write_en,
   output reg         sb2_write_en,
   // Decoded settings
   output reg         cfg_valid,
   output reg         watchdog_reset_en,
   output reg         watchdog_irq_en,
   output reg         reset_pin_is_input,
   output reg         port_reset_high,
   output reg         brownout_low_thresh,
   output reg         standard_cycle,
   output reg  [4:0]  osc_source,
   output reg         osc_reserved,
   output reg         sec_unsupported
);
   reg  [7:0] system_config_byte_one;
   reg        security_bit_one;
   reg        security_bit_two;
   reg        loaded;
   reg  [4:0] next_src;
   reg        next_rsv;
   wire       prog_allow;
   wire       verify_allow;
   wire       sb2_prog_allow;
   wire       unsupported;

   pcfg_security u_sec
   (
      .security_bit_one (security_bit_one),
      .security_bit_two (security_bit_two),
      .prog_allow       (prog_allow),
      .verify_allow     (verify_allow),
      .sb2_prog_allow   (sb2_prog_allow),
      .unsupported      (unsupported)
   );

   // One capture after reset release, then frozen
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         system_config_byte_one <= `PCFG_CFG1_RESET;
         security_bit_one       <= 1'b1;
         security_bit_two       <= 1'b1;
         loaded                 <= 1'b0;
      end
      else if (!loaded)
      begin
         system_config_byte_one <= nv_cfg1;
         security_bit_one       <= nv_sb1;
         security_bit_two       <= nv_sb2;
         loaded                 <= 1'b1;
      end
   end

   always @*
   begin
      next_src = 5'h00;
      next_rsv = 1'b0;
      case (system_config_byte_one[`PCFG_OSC_HI:`PCFG_OSC_LO])
         `PCFG_OSC_EXT:  next_src[`PCFG_SRC_EXT]  = 1'b1;
         `PCFG_OSC_RC:   next_src[`PCFG_SRC_RC]   = 1'b1;
         `PCFG_OSC_LOW:  next_src[`PCFG_SRC_LOW]  = 1'b1;
         `PCFG_OSC_MED:  next_src[`PCFG_SRC_MED]  = 1'b1;
         `PCFG_OSC_HIGH: next_src[`PCFG_SRC_HIGH] = 1'b1;
         default:        next_rsv = 1'b1;
      endcase
   end

   // Registered decode of settings
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_valid           <= 1'b0;
         watchdog_reset_en   <= 1'b1;
         watchdog_irq_en     <= 1'b1;
         reset_pin_is_input  <= 1'b1;
         port_reset_high     <= 1'b1;
         brownout_low_thresh <= 1'b1;
         standard_cycle      <= 1'b1;
         osc_source          <= 5'h01;
         osc_reserved        <= 1'b0;
         sec_unsupported     <= 1'b0;
      end
      else
      begin
         cfg_valid           <= loaded;
         watchdog_reset_en   <=
            system_config_byte_one[`PCFG_WATCHDOG_ENABLE_CFG_BIT];
         watchdog_irq_en     <= 1'b1;
         reset_pin_is_input  <=
            system_config_byte_one[`PCFG_RPD_BIT];
         port_reset_high     <=
            system_config_byte_one[`PCFG_PORT_RESET_LEVEL_CFG_BIT];
         brownout_low_thresh <=
            system_config_byte_one[`PCFG_BOV_BIT];
         standard_cycle      <=
            system_config_byte_one[`PCFG_CLOCK_RATE_CFG_BIT];
         osc_source          <= next_src;
         osc_reserved        <= next_rsv;
         sec_unsupported     <= unsupported;
      end
   end

   // Read-only external-data read, one cycle latency
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         xrd_data <= 8'h00;
         xrd_hit  <= 1'b0;
      end
      else if (xrd_req && xrd_addr == `PCFG_CFG1_ADDR)
      begin
         xrd_data <= system_config_byte_one;
         xrd_hit  <= 1'b1;
      end
      else
      begin
         xrd_data <= 8'h00;
         xrd_hit  <= 1'b0;
      end
   end

   // Programmer commands gated by security state
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pgm_ack       <= 1'b0;
         pgm_refused   <= 1'b0;
         pgm_rdata     <= 8'h00;
         code_write_en <= 1'b0;
         sb1_write_en  <= 1'b0;
         sb2_write_en  <= 1'b0;
      end
      else
      begin
         pgm_ack       <= 1'b0;
         pgm_refused   <= 1'b0;
         code_write_en <= 1'b0;
         sb1_write_en  <= 1'b0;
         sb2_write_en  <= 1'b0;
         if (pgm_req && loaded)
         begin
            pgm_ack <= 1'b1;
            case (pgm_cmd)
               `PCFG_CMD_PROG:
               begin
                  code_write_en <= prog_allow;
                  pgm_refused   <= ~prog_allow;
               end
               `PCFG_CMD_VERIFY:
               begin
                  pgm_rdata   <= verify_allow ? pgm_code_rdata
                                              : 8'hFF;
                  pgm_refused <= ~verify_allow;
               end
               `PCFG_CMD_PROG_SB1:
               begin
                  sb1_write_en <= prog_allow;
                  pgm_refused  <= ~prog_allow;
               end
               default:
               begin
                  sb2_write_en <= sb2_prog_allow;
                  pgm_refused  <= ~sb2_prog_allow;
               end
            endcase
         end
      end
   end
endmodule

/* testbench/pcfg_chk.sv */
`timescale 1ns/1ps
module pcfg_chk
(
   // Clock, reset, requests
   input wire        clk, rst_b, xrd_req, pgm_req, nv_sb1, nv_sb2,
   input wire [15:0] xrd_addr,
   input wire [1:0]  pgm_cmd,
   input wire [7:0]  nv_cfg1, pgm_code_rdata, xrd_data, pgm_rdata,
   // Answers and settings
   input wire        xrd_hit, pgm_ack, pgm_refused, code_write_en,
   input wire        sb2_write_en, cfg_valid, watchdog_reset_en,
   input wire        watchdog_irq_en, reset_pin_is_input, port_reset_high,
   input wire        brownout_low_thresh, standard_cycle
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire       cmd_ok = pgm_req && cfg_valid;
   wire [4:0] flags = {watchdog_reset_en, reset_pin_is_input,
                       port_reset_high, brownout_low_thresh, standard_cycle};
   a_read_hit: assert property (xrd_req && xrd_addr == 16'hFD00
      |=> xrd_hit) else $error("read not answered");
   a_read_miss: assert property (xrd_req && xrd_addr != 16'hFD00
      |=> !xrd_hit && xrd_data == 8'h00) else $error("stray read hit");
   a_cmd_ack: assert property (cmd_ok |=> pgm_ack)
      else $error("command not acknowledged");
   a_prog_shut: assert property (cmd_ok && pgm_cmd == 2'h0
      && !(nv_sb1 && nv_sb2) |=> pgm_refused && !code_write_en)
      else $error("locked programming accepted");
   a_verify_open: assert property (cmd_ok && pgm_cmd == 2'h1
      && nv_sb2 |=> !pgm_refused && pgm_rdata == $past(pgm_code_rdata))
      else $error("verify data wrong");
   a_verify_shut: assert property (cmd_ok && pgm_cmd == 2'h1
      && !nv_sb2 |=> pgm_refused && pgm_rdata == 8'hFF)
      else $error("verify leaked");
   a_sb2_open: assert property (cmd_ok && pgm_cmd == 2'h3
      && nv_sb2 && !nv_sb1 |=> sb2_write_en) else $error("bit two refused");
   a_load_value: assert property ($rose(cfg_valid)
      |-> flags == nv_cfg1[7:3] && watchdog_irq_en)
      else $error("settings decoded wrong");
   a_settings_hold: assert property (cfg_valid && $past(cfg_valid)
      |-> $stable(flags)) else $error("settings changed");
   c_verify: cover property (cmd_ok && pgm_cmd == 2'h1 && nv_sb2);
   c_refuse: cover property (pgm_refused);
   c_read: cover property (xrd_hit);
endmodule
bind pcfg_loader pcfg_chk chk (.*);

/* testbench/pcfg_prog_model.sv */
`timescale 1ns/1ps
module pcfg_prog_model
(
   // Clock and security state {two, one}
   input  wire       clk,
   input  wire [1:0] sec_state,
   // Array contents seen by the device
   output wire       nv_sb1,
   output wire       nv_sb2,
   output reg  [7:0] pgm_code_rdata
);
   // Bit two never programmed alone
   assign nv_sb1 = sec_state[0] & sec_state[1];
   assign nv_sb2 = sec_state[1];
   // Code array data, changing every cycle
   initial pgm_code_rdata = 8'h5A;
   always @(posedge clk)
      pgm_code_rdata <= pgm_code_rdata + 8'h3B;
endmodule

/* testbench/powerup_config_and_code_security_bench.sv */
`timescale 1ns/1ps
module powerup_config_and_code_security_bench;
   reg clk = 0, rst_b = 0, xrd_req = 0, pgm_req = 0;
   reg [7:0] nv_cfg1 = 8'hFF, v, d;
   reg [15:0] xrd_addr = 16'h0000;
   reg [1:0] pgm_cmd = 2'h0, sec = 2'h3;
   wire [7:0] xrd_data, pgm_rdata, pgm_code_rdata;
   wire [4:0] osc_source;
   wire nv_sb1, nv_sb2, xrd_hit, pgm_ack, pgm_refused, code_write_en,
      sb1_write_en, sb2_write_en, cfg_valid, watchdog_reset_en,
      watchdog_irq_en, reset_pin_is_input, port_reset_high,
      brownout_low_thresh, standard_cycle, osc_reserved, sec_unsupported;
   integer failures = 0, compares = 0, i, n;
   always #25 clk = ~clk;
   pcfg_loader dut (.*);
   pcfg_prog_model partner (.clk(clk), .sec_state(sec), .nv_sb1(nv_sb1),
      .nv_sb2(nv_sb2), .pgm_code_rdata(pgm_code_rdata));
   task chk(input [7:0] seen, input [7:0] exp);
   begin
      compares = compares + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task conclude;
   begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   task boot(input [7:0] cfg, input [1:0] s);
   begin
      rst_b = 0; nv_cfg1 = cfg; sec = s;
      repeat (6) @(posedge clk);
      #1 rst_b = 1;
      for (n = 0; n < 20 && cfg_valid !== 1'b1; n = n + 1)
         @(posedge clk) #1;
      if (n == 20)
      begin
         failures = failures + 1;
         conclude;
      end
      @(posedge clk) #1;
   end
   endtask
   function [5:0] osc_exp(input [2:0] c);
      case (c)
         3'h7: osc_exp = 6'h01;
         3'h3: osc_exp = 6'h02;
         3'h2: osc_exp = 6'h04;
         3'h1: osc_exp = 6'h08;
         3'h0: osc_exp = 6'h10;
         default: osc_exp = 6'h20;
      endcase
   endfunction
   task t_config;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         v = {i[2:0] ^ 3'h5, i[1:0], i[2:0]};
         boot(v, 2'h3);
         nv_cfg1 = ~v;
         xrd_req = 1; xrd_addr = 16'hFD00;
         @(posedge clk) #1 xrd_addr = 16'hFD01;
         chk(xrd_hit, 1); chk(xrd_data, v);
         @(posedge clk) #1 xrd_req = 0;
         chk(xrd_hit, 0); chk(xrd_data, 0);
         chk({watchdog_irq_en, watchdog_reset_en, reset_pin_is_input,
            port_reset_high, brownout_low_thresh, standard_cycle},
            {1'b1, v[7:3]});
         chk({osc_reserved, osc_source & {5{~osc_reserved}}},
            osc_exp(v[2:0]));
      end
      $display("config test done");
   end
   endtask
   task t_sec(input [1:0] s, input [3:0] refuse);
   begin
      boot(8'hFF, s);
      pgm_req = 1;
      for (i = 0; i < 4; i = i + 1)
      begin
         pgm_cmd = i[1:0]; d = pgm_code_rdata;
         @(posedge clk) #1;
         chk(pgm_ack, 1); chk(pgm_refused, refuse[i]);
         chk({code_write_en, sb1_write_en, sb2_write_en}, {i == 0, i == 2,
            i == 3} & {3{~refuse[i]}});
         if (i == 1)
            chk(pgm_rdata, refuse[1] ? 8'hFF : d);
         chk(sec_unsupported, 0);
      end
      pgm_req = 0;
      @(posedge clk) #1 chk(pgm_ack, 0);
      $display("security test %h done", s);
   end
   endtask
   initial
   begin
      t_config;
      t_sec(2'h3, 4'h0);
      t_sec(2'h2, 4'h5);
      t_sec(2'h0, 4'hF);
      conclude;
   end
endmodule
